// ---- logic/reset_strap_sampler.v ----
// Design decisions made here: the strobed register port and the register addresses.
`timescale 1ns/1ps
`include "reset_strap_sampler_consts.vh"

// What this block does
// - latch method select bit 2 at reset release to pick configuration.
// - packages lacking method select bit 2 see it as zero.
// - tied-high reset relies on power-on reset until supplies stable.
// - active state led asserted only when configured and not suspended.
// - self power sense low means bus powered, high means self powered.
// - fixed port strap code 00..11 marks none, port 1, 1-2, 1-3 fixed.
// - active state led active high for codes 00,10, low for 01,11.
// - external clock frequency pick zero means 24 MHz; one means 48 MHz only when the external clock is used.
// - code 001 is management slave at fixed address, 011 loads eeprom.
// - method select bit 1 zero makes speed led active high, one low.
module reset_strap_sampler #(
  parameter HAS_SEL2      = 1,
  parameter SETTLE_CYCLES = `POR_SETTLE_CYCLES,
  parameter MIN_CYCLES    = `RESET_MIN_CYCLES
) (
  // clock and reset
  input  wire       i_clock,
  input  wire       i_sys_rst,
  // reset sources
  input  wire       i_ext_reset_n,
  input  wire       i_supplies_stable,
  // dedicated strap inputs
  input  wire       i_method_select_bit0,
  input  wire       i_method_select_bit2,
  input  wire       i_fixed_port_strap_bit1,
  input  wire       i_ext_clock_freq_pick,
  input  wire       i_ext_clock_used,
  // shared pin: upstream speed led / method select bit 1
  input  wire       i_upstream_speed_led,
  output reg        o_upstream_speed_led,
  output reg        o_upstream_speed_led_oe,
  // shared pin: active state led / self power / fixed port bit 0
  input  wire       i_active_state_led,
  output reg        o_active_state_led,
  output reg        o_active_state_led_oe,
  // hub state
  input  wire       i_hub_configured,
  input  wire       i_hub_suspended,
  input  wire       i_hub_high_speed,
  // decoded configuration
  output wire       o_core_rst,
  output reg        o_cfg_valid,
  output reg        o_cfg_strap_en,
  output reg        o_cfg_smbus_slave,
  output reg        o_cfg_eeprom_load,
  output reg        o_cfg_internal_default,
  output reg  [6:0] o_smbus_addr,
  output reg  [2:0] o_fixed_ports,
  output reg        o_self_powered,
  output reg        o_clock_48m,
  // register port
  input  wire [3:0] i_reg_addr,
  input  wire [7:0] i_reg_wdata,
  input  wire       i_reg_wr,
  input  wire       i_reg_rd,
  output reg  [7:0] o_reg_rdata
);

  wire                    core_rst;
  wire                    release_pulse;
  wire                    short_pulse;
  wire [`STRAP_WIDTH-1:0] strap_pins;
  wire [`STRAP_WIDTH-1:0] strap_q;
  wire                    strap_valid;
  wire [2:0]              method;
  wire [1:0]              fix_code;
  reg                     strap_en_d;
  reg                     smbus_d;
  reg                     eeprom_d;
  reg                     default_d;
  reg  [2:0]              fix_mask_d;
  reg  [7:0]              control_q;
  reg  [7:0]              rdata_d;
  wire                    ind_en;
  wire                    led_active;
  wire                    led_low;
  wire                    speed_low;
  wire                    sel2_pin;
  wire                    core_clear;
  wire                    ctrl_wr;

  por_reset_gen #(
    .SETTLE_CYCLES (SETTLE_CYCLES),
    .MIN_CYCLES    (MIN_CYCLES),
    .CNT_W         (16)
  ) u_por (
    .i_clock           (i_clock),
    .i_sys_rst         (i_sys_rst),
    .i_ext_reset_n     (i_ext_reset_n),
    .i_supplies_stable (i_supplies_stable),
    .o_core_rst        (core_rst),
    .o_release         (release_pulse),
    .o_short_pulse     (short_pulse)
  );

  assign o_core_rst = core_rst;

  // either reset source clears everything derived from the straps
  assign core_clear = i_sys_rst | core_rst;

  // missing package pin reads as zero; the input is then left unread
  generate
    if (HAS_SEL2 != 0) begin : g_sel2_pin
      assign sel2_pin = i_method_select_bit2;
    end else begin : g_sel2_tied
      assign sel2_pin = 1'b0;
    end
  endgenerate

  // dedicated strap pins
  assign strap_pins[`STRAP_SEL0] = i_method_select_bit0;
  assign strap_pins[`STRAP_SEL2] = sel2_pin;
  assign strap_pins[`STRAP_FIX1] = i_fixed_port_strap_bit1;
  assign strap_pins[`STRAP_FREQ] = i_ext_clock_freq_pick;

  // shared pins are still inputs here since their drivers are off
  assign strap_pins[`STRAP_SEL1] = i_upstream_speed_led;
  assign strap_pins[`STRAP_FIX0] = i_active_state_led;

  // capture on the release edge, one sample per reset
  strap_latch #(
    .WIDTH (`STRAP_WIDTH)
  ) u_latch (
    .i_clock   (i_clock),
    .i_sys_rst (core_clear),
    .i_capture (release_pulse),
    .i_pins    (strap_pins),
    .o_value   (strap_q),
    .o_valid   (strap_valid)
  );

  assign method   = {strap_q[`STRAP_SEL2], strap_q[`STRAP_SEL1],
                     strap_q[`STRAP_SEL0]};
  assign fix_code = {strap_q[`STRAP_FIX1], strap_q[`STRAP_FIX0]};

  // method decode
  always @* begin
    strap_en_d = 1'b0;
    smbus_d    = 1'b0;
    eeprom_d   = 1'b0;
    default_d  = 1'b0;
    case (method)
      `METHOD_STRAP_A: begin
        strap_en_d = 1'b1;
        default_d  = 1'b1;
      end
      `METHOD_STRAP_B: begin
        strap_en_d = 1'b1;
        default_d  = 1'b1;
      end
      `METHOD_SMBUS: begin
        smbus_d = 1'b1;
      end
      `METHOD_EEPROM: begin
        eeprom_d = 1'b1;
      end
      // bit 2 set: internal default, straps ignored
      3'h4: begin
        default_d = 1'b1;
      end
      3'h5: begin
        default_d = 1'b1;
      end
      3'h6: begin
        default_d = 1'b1;
      end
      3'h7: begin
        default_d = 1'b1;
      end
      default: begin
        default_d = 1'b1;
      end
    endcase
  end

  // fixed port mask, only honoured when straps are enabled
  always @* begin
    fix_mask_d = 3'h0;
    if (strap_en_d) begin
      case (fix_code)
        2'h0:    fix_mask_d = 3'h0;
        2'h1:    fix_mask_d = 3'h1;
        2'h2:    fix_mask_d = 3'h3;
        2'h3:    fix_mask_d = 3'h7;
        default: fix_mask_d = 3'h0;
      endcase
    end
  end

  // method flags and slave address stand until the next core reset
  always @(posedge i_clock) begin
    if (core_clear) begin
      o_cfg_valid            <= 1'b0;
      o_cfg_strap_en         <= 1'b0;
      o_cfg_smbus_slave      <= 1'b0;
      o_cfg_eeprom_load      <= 1'b0;
      o_cfg_internal_default <= 1'b0;
      o_smbus_addr           <= 7'h00;
    end else if (strap_valid) begin
      o_cfg_valid            <= 1'b1;
      o_cfg_strap_en         <= strap_en_d;
      o_cfg_smbus_slave      <= smbus_d;
      o_cfg_eeprom_load      <= eeprom_d;
      o_cfg_internal_default <= default_d;
      o_smbus_addr           <= smbus_d ? `SMBUS_SLAVE_ADDR : 7'h00;
    end
  end

  // sense shares the fixed bit 0 pin, so it is only seen at release
  always @(posedge i_clock) begin
    if (core_clear) begin
      o_fixed_ports  <= 3'h0;
      o_self_powered <= 1'b0;
      o_clock_48m    <= 1'b0;
    end else if (strap_valid) begin
      o_fixed_ports  <= fix_mask_d;
      // low sense means all power comes from upstream
      o_self_powered <= strap_q[`STRAP_FIX0];
      o_clock_48m    <= i_ext_clock_used & strap_q[`STRAP_FREQ];
    end
  end

  // polarity follows the raw sampled code even with straps disabled
  assign led_low    = fix_code[0];
  assign speed_low  = strap_q[`STRAP_SEL1];
  assign led_active = i_hub_configured & ~i_hub_suspended;
  assign ind_en     = control_q[`CTRL_IND_EN];

  // active state pin; its driver stays off until the straps are latched
  always @(posedge i_clock) begin
    if (core_clear) begin
      o_active_state_led    <= 1'b0;
      o_active_state_led_oe <= 1'b0;
    end else begin
      o_active_state_led    <= led_active ^ led_low;
      o_active_state_led_oe <= strap_valid & ind_en;
    end
  end

  // upstream speed pin, gated the same way
  always @(posedge i_clock) begin
    if (core_clear) begin
      o_upstream_speed_led    <= 1'b0;
      o_upstream_speed_led_oe <= 1'b0;
    end else begin
      o_upstream_speed_led    <= i_hub_high_speed ^ speed_low;
      o_upstream_speed_led_oe <= strap_valid & ind_en;
    end
  end

  // register port: control survives core reset, only system reset clears
  assign ctrl_wr = i_reg_wr & (i_reg_addr == `REG_CONTROL);

  always @(posedge i_clock) begin
    if (i_sys_rst) begin
      control_q <= `CTRL_RESET;
    end else if (ctrl_wr) begin
      // bits above the enable do not exist and read back as zero
      control_q <= i_reg_wdata & 8'h01;
    end
  end

  always @* begin
    rdata_d = 8'h00;
    case (i_reg_addr)
      `REG_STATUS: begin
        rdata_d[`STAT_LATCHED]   = o_cfg_valid;
        rdata_d[`STAT_SELF_PWR]  = o_self_powered;
        rdata_d[`STAT_CLK48]     = o_clock_48m;
        rdata_d[`STAT_CORE_RST]  = core_rst;
        rdata_d[`STAT_SHORT_RST] = short_pulse;
      end
      `REG_CONTROL: begin
        rdata_d = control_q;
      end
      `REG_CONFIG: begin
        rdata_d[`CFG_METHOD_LSB+2:`CFG_METHOD_LSB]   = method;
        rdata_d[`CFG_FIXCODE_LSB+1:`CFG_FIXCODE_LSB] = fix_code;
        rdata_d[`CFG_STRAP_EN]                       = o_cfg_strap_en;
      end
      default: begin
        rdata_d = 8'h00;
      end
    endcase
  end

  // read data stand only in the cycle after the strobe
  always @(posedge i_clock) begin
    if (i_sys_rst)
      o_reg_rdata <= 8'h00;
    else if (i_reg_rd)
      o_reg_rdata <= rdata_d;
    else
      o_reg_rdata <= 8'h00;
  end

endmodule

// ---- logic/reset_strap_sampler_consts.vh ----
`ifndef RESET_STRAP_SAMPLER_CONSTS_VH
`define RESET_STRAP_SAMPLER_CONSTS_VH

// clock and timing
`define CLOCK_MHZ            200
`define RESET_MIN_NS         1000
`define RESET_MIN_CYCLES     ((`RESET_MIN_NS * `CLOCK_MHZ + 999) / 1000)
`define POR_SETTLE_NS        1000
`define POR_SETTLE_CYCLES    ((`POR_SETTLE_NS * `CLOCK_MHZ + 999) / 1000)

// configuration method codes {bit2, bit1, bit0}
`define METHOD_STRAP_A       3'h0
`define METHOD_SMBUS         3'h1
`define METHOD_STRAP_B       3'h2
`define METHOD_EEPROM        3'h3

`define SMBUS_SLAVE_ADDR     7'h2C

// latched strap vector positions
`define STRAP_SEL0           0
`define STRAP_SEL1           1
`define STRAP_SEL2           2
`define STRAP_FIX0           3
`define STRAP_FIX1           4
`define STRAP_FREQ           5
`define STRAP_WIDTH          6

// register offsets
`define REG_STATUS           4'h0
`define REG_CONTROL          4'h4
`define REG_CONFIG           4'h8

// control fields and reset value
`define CTRL_IND_EN          0
`define CTRL_RESET           8'h01

// status fields
`define STAT_LATCHED         0
`define STAT_SELF_PWR        1
`define STAT_CLK48           2
`define STAT_CORE_RST        3
`define STAT_SHORT_RST       4

// config fields
`define CFG_METHOD_LSB       0
`define CFG_FIXCODE_LSB      3
`define CFG_STRAP_EN         5
`define CFG_FIXMASK_LSB      8

`endif

// ---- logic/por_reset_gen.v ----
`timescale 1ns/1ps
`include "reset_strap_sampler_consts.vh"

module por_reset_gen #(
  parameter SETTLE_CYCLES = `POR_SETTLE_CYCLES,
  parameter MIN_CYCLES    = `RESET_MIN_CYCLES,
  parameter CNT_W         = 16
) (
  // clock and reset
  input  wire i_clock,
  input  wire i_sys_rst,
  // reset sources
  input  wire i_ext_reset_n,
  input  wire i_supplies_stable,
  // results
  output reg  o_core_rst,
  output reg  o_release,
  output reg  o_short_pulse
);

  localparam [CNT_W-1:0] ONE         = {{(CNT_W-1){1'b0}}, 1'b1};
  localparam [CNT_W-1:0] SETTLE_LAST = SETTLE_CYCLES[CNT_W-1:0] - ONE;
  // a pulse is long once it has been low for the full minimum count
  localparam [CNT_W-1:0] MIN_FULL    = MIN_CYCLES[CNT_W-1:0];

  reg  [CNT_W-1:0] settle_q;
  reg  [CNT_W-1:0] low_q;
  wire             cause;

  // a tied-high external reset leaves supply stability as the only cause
  assign cause = ~i_ext_reset_n | ~i_supplies_stable;

  always @(posedge i_clock) begin
    if (i_sys_rst) begin
      settle_q      <= {CNT_W{1'b0}};
      low_q         <= {CNT_W{1'b0}};
      o_core_rst    <= 1'b1;
      o_release     <= 1'b0;
      o_short_pulse <= 1'b0;
    end else begin
      o_release <= 1'b0;
      if (cause) begin
        settle_q   <= {CNT_W{1'b0}};
        o_core_rst <= 1'b1;
      end else if (settle_q != SETTLE_LAST) begin
        settle_q <= settle_q + {{(CNT_W-1){1'b0}}, 1'b1};
      end else if (o_core_rst) begin
        o_core_rst <= 1'b0;
        o_release  <= 1'b1;
      end
      // pulses below the minimum are still honoured, only flagged
      if (~i_ext_reset_n) begin
        if (low_q != MIN_FULL)
          low_q <= low_q + {{(CNT_W-1){1'b0}}, 1'b1};
      end else begin
        low_q <= {CNT_W{1'b0}};
      end
      if (~i_ext_reset_n & i_supplies_stable) begin
        o_short_pulse <= 1'b0;
      end else if (i_ext_reset_n & (low_q != {CNT_W{1'b0}})
                   & (low_q != MIN_FULL)) begin
        o_short_pulse <= 1'b1;
      end
    end
  end

endmodule

// ---- logic/strap_latch.v ----
`timescale 1ns/1ps

module strap_latch #(
  parameter WIDTH = 6
) (
  // clock and reset
  input  wire             i_clock,
  input  wire             i_sys_rst,
  // capture
  input  wire             i_capture,
  input  wire [WIDTH-1:0] i_pins,
  // latched values
  output wire [WIDTH-1:0] o_value,
  output reg              o_valid
);

  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
      reg bit_q;
      always @(posedge i_clock) begin
        if (i_sys_rst)
          bit_q <= 1'b0;
        else if (i_capture)
          bit_q <= i_pins[g];
      end
      assign o_value[g] = bit_q;
    end
  endgenerate

  always @(posedge i_clock) begin
    if (i_sys_rst)
      o_valid <= 1'b0;
    else if (i_capture)
      o_valid <= 1'b1;
  end

endmodule

// ---- bench/rss_assertions.sv ----
`timescale 1ns/1ps
module rss_checker (
  input wire       i_clock,
  input wire       i_sys_rst,
  input wire       i_ext_reset_n,
  input wire       i_supplies_stable,
  input wire       i_ext_clock_used,
  input wire       i_hub_configured,
  input wire       i_hub_suspended,
  input wire       o_core_rst,
  input wire       o_cfg_valid,
  input wire       o_cfg_strap_en,
  input wire       o_cfg_smbus_slave,
  input wire       o_cfg_eeprom_load,
  input wire       o_cfg_internal_default,
  input wire [6:0] o_smbus_addr,
  input wire [2:0] o_fixed_ports,
  input wire       o_clock_48m,
  input wire       o_active_state_led,
  input wire       o_active_state_led_oe,
  input wire       o_upstream_speed_led_oe
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  a_pin_reset_hold: assert property (!i_ext_reset_n |=> o_core_rst)
    else $error("core reset not raised by reset pin");
  a_por_supply_hold: assert property (!i_supplies_stable |=> o_core_rst)
    else $error("core reset not held while supplies unstable");
  a_cfg_after_release: assert property (
    $fell(o_core_rst) |-> ##[2:3] o_cfg_valid)
    else $error("configuration not valid after release");
  a_pins_undriven: assert property (
    o_active_state_led_oe || o_upstream_speed_led_oe |-> o_cfg_valid)
    else $error("shared pin driven before straps latched");
  a_led_polarity: assert property (
    o_active_state_led_oe && $past(o_active_state_led_oe) && o_cfg_strap_en
    |-> o_active_state_led ==
        ($past(i_hub_configured && !i_hub_suspended) ^ (^o_fixed_ports)))
    else $error("active state led level wrong");
  a_fixed_masked: assert property (
    o_cfg_valid && !o_cfg_strap_en |-> o_fixed_ports == 3'h0)
    else $error("fixed ports set with straps disabled");
  a_slave_address: assert property (
    o_cfg_smbus_slave |-> o_smbus_addr == 7'h2C && !o_cfg_strap_en)
    else $error("management slave address wrong");
  a_method_onehot: assert property (
    o_cfg_valid |-> $onehot({o_cfg_smbus_slave, o_cfg_eeprom_load,
                             o_cfg_internal_default}))
    else $error("configuration methods not exclusive");
  a_clock_24m: assert property (
    o_cfg_valid && !i_ext_clock_used |=> !o_clock_48m)
    else $error("48 MHz picked without external clock");
  cover property ($fell(o_core_rst));
  cover property (o_cfg_smbus_slave);
  cover property (o_cfg_eeprom_load);
  cover property (o_active_state_led_oe && o_active_state_led);
endmodule

// ---- bench/board_model.sv ----
`timescale 1ns/1ps
// straps are resistors: an undriven pin settles to its strap level
module board_model (
  input  wire [5:0] i_straps,
  input  wire       i_led_a,
  input  wire       i_oe_a,
  input  wire       i_led_s,
  input  wire       i_oe_s,
  output wire       o_pin_a,
  output wire       o_pin_s
);
  assign o_pin_a = i_oe_a ? i_led_a : i_straps[3];
  assign o_pin_s = i_oe_s ? i_led_s : i_straps[1];
endmodule

// ---- bench/reset_strap_sampler_tb_top.sv ----
`timescale 1ns/1ps
module reset_strap_sampler_tb_top;
  reg        i_clock = 0, i_sys_rst = 1, i_ext_reset_n = 0;
  reg        i_supplies_stable = 1, i_ext_clock_used = 0;
  reg        i_hub_configured = 0, i_hub_suspended = 0, i_hub_high_speed = 0;
  reg  [3:0] i_reg_addr = 4'h0;
  reg  [7:0] i_reg_wdata = 8'h00;
  reg        i_reg_wr = 0, i_reg_rd = 0, rd_seen = 0;
  reg  [5:0] st = 6'h00;
  reg  [15:0] r = 16'h384A;
  reg  [2:0] m, mask;
  reg        en;
  integer    failures = 0, checked = 0, cyc = 0, i, k;
  reg  [7:0] exp_q[$];
  wire       pin_a, pin_s, led_a, oe_a, led_s, oe_s, core_rst, cfg_valid;
  wire       eeprom, smbus, dflt, smbus2, eeprom2;
  wire [6:0] addr7;
  wire [2:0] fixed;
  wire [7:0] rdata;
  reset_strap_sampler #(.SETTLE_CYCLES(4), .MIN_CYCLES(4)) dut (
    .i_clock(i_clock), .i_sys_rst(i_sys_rst),
    .i_ext_reset_n(i_ext_reset_n), .i_supplies_stable(i_supplies_stable),
    .i_method_select_bit0(st[0]), .i_method_select_bit2(st[2]),
    .i_fixed_port_strap_bit1(st[4]), .i_ext_clock_freq_pick(st[5]),
    .i_ext_clock_used(i_ext_clock_used),
    .i_upstream_speed_led(pin_s), .o_upstream_speed_led(led_s),
    .o_upstream_speed_led_oe(oe_s), .i_active_state_led(pin_a),
    .o_active_state_led(led_a), .o_active_state_led_oe(oe_a),
    .i_hub_configured(i_hub_configured), .i_hub_suspended(i_hub_suspended),
    .i_hub_high_speed(i_hub_high_speed), .o_core_rst(core_rst),
    .o_cfg_valid(cfg_valid), .o_cfg_strap_en(), .o_cfg_smbus_slave(smbus),
    .o_cfg_eeprom_load(eeprom), .o_cfg_internal_default(dflt),
    .o_smbus_addr(addr7), .o_fixed_ports(fixed), .o_self_powered(),
    .o_clock_48m(), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(rdata));
  // package without method select bit 2, sharing the straps of dut
  reset_strap_sampler #(.HAS_SEL2(0), .SETTLE_CYCLES(4), .MIN_CYCLES(4))
    dut2 (
    .i_clock(i_clock), .i_sys_rst(i_sys_rst),
    .i_ext_reset_n(i_ext_reset_n), .i_supplies_stable(i_supplies_stable),
    .i_method_select_bit0(st[0]), .i_method_select_bit2(st[2]),
    .i_fixed_port_strap_bit1(st[4]), .i_ext_clock_freq_pick(st[5]),
    .i_ext_clock_used(i_ext_clock_used),
    .i_upstream_speed_led(pin_s), .o_upstream_speed_led(),
    .o_upstream_speed_led_oe(), .i_active_state_led(pin_a),
    .o_active_state_led(), .o_active_state_led_oe(),
    .i_hub_configured(i_hub_configured), .i_hub_suspended(i_hub_suspended),
    .i_hub_high_speed(i_hub_high_speed), .o_core_rst(),
    .o_cfg_valid(), .o_cfg_strap_en(), .o_cfg_smbus_slave(smbus2),
    .o_cfg_eeprom_load(eeprom2), .o_cfg_internal_default(),
    .o_smbus_addr(), .o_fixed_ports(), .o_self_powered(),
    .o_clock_48m(), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata());
  board_model u_board (.i_straps(st), .i_led_a(led_a), .i_oe_a(oe_a),
    .i_led_s(led_s), .i_oe_s(oe_s), .o_pin_a(pin_a), .o_pin_s(pin_s));
  initial forever #2.5 i_clock = ~i_clock;
  function [15:0] lfsr(input [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task check(input string nm, input [7:0] seen, input [7:0] exp);
    checked = checked + 1;
    if (seen !== exp) begin
      failures = failures + 1;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task end_of_test;
    if (exp_q.size() != 0) failures = failures + 1;
    if (failures == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task rd(input [3:0] a, input [7:0] e);
    exp_q.push_back(e);
    i_reg_addr <= a;
    i_reg_rd <= 1;
    @(posedge i_clock) i_reg_rd <= 0;
    @(posedge i_clock);
  endtask
  task wr(input [3:0] a, input [7:0] d);
    i_reg_addr <= a;
    i_reg_wdata <= d;
    i_reg_wr <= 1;
    @(posedge i_clock) i_reg_wr <= 0;
    @(posedge i_clock);
  endtask
  // wait is bounded so a dead release path counts a failure instead of hanging
  task wait_valid;
    k = 0;
    while (cfg_valid !== 1'b1 && k < 50) begin
      @(posedge i_clock);
      k = k + 1;
    end
    if (k >= 50) failures = failures + 1;
    @(posedge i_clock);
  endtask
  task pulse(input integer n);
    i_ext_reset_n <= 0;
    repeat (n) @(posedge i_clock);
    i_ext_reset_n <= 1;
    // drivers fall two edges into the pulse, so look once it is over
    @(posedge i_clock);
    check("led_oe", {oe_a, oe_s}, 8'h00);
    check("pin_a", pin_a, st[3]);
    check("pin_s", pin_s, st[1]);
    wait_valid;
  endtask
  always @(posedge i_clock) begin
    if (rd_seen) check("reg_rdata", rdata, exp_q.pop_front());
    rd_seen <= i_reg_rd;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures = failures + 1;
      end_of_test;
    end
  end
  initial begin
    repeat (12) @(posedge i_clock);
    i_sys_rst <= 0;
    @(posedge i_clock);
    rd(4'h4, 8'h01);
    for (i = 0; i < 24; i = i + 1) begin
      r = lfsr(r);
      st <= r[5:0];
      {i_ext_clock_used, i_hub_configured} <= r[7:6];
      {i_hub_suspended, i_hub_high_speed} <= r[9:8];
      @(posedge i_clock);
      pulse(6);
      m = st[2:0];
      en = (m == 3'h0) || (m == 3'h2);
      mask = en ? {st[4] & st[3], st[4], st[4] | st[3]} : 3'h0;
      rd(4'h8, {2'h0, en, st[4:3], m});
      rd(4'h0, {5'h00, i_ext_clock_used & st[5], st[3], 1'b1});
      check("fixed_ports", fixed, mask);
      check("smbus_addr", addr7, m == 3'h1 ? 7'h2C : 7'h00);
      check("eeprom_load", eeprom, m == 3'h3);
      check("state_led", led_a,
            (i_hub_configured & ~i_hub_suspended) ^ st[3]);
      check("speed_led", led_s, i_hub_high_speed ^ st[1]);
      check("smbus_slave", smbus, m == 3'h1);
      check("int_default", dflt, m != 3'h1 && m != 3'h3);
      check("sel2_absent", {smbus2, eeprom2},
            {m[1:0] == 2'h1, m[1:0] == 2'h3});
    end
    pulse(2);
    rd(4'h0, {3'h0, 2'h2, i_ext_clock_used & st[5], st[3], 1'b1});
    i_supplies_stable <= 0;
    repeat (3) @(posedge i_clock);
    check("core_rst", core_rst, 1'b1);
    check("led_oe", {oe_a, oe_s}, 8'h00);
    i_supplies_stable <= 1;
    wait_valid;
    wr(4'h4, 8'hFE);
    rd(4'h4, 8'h00);
    check("led_oe", {oe_a, oe_s}, 8'h00);
    wr(4'hC, 8'hFF);
    rd(4'hC, 8'h00);
    wr(4'h4, 8'hFF);
    rd(4'h4, 8'h01);
    // let the monitor take the last read before closing
    @(posedge i_clock);
    end_of_test;
  end
endmodule
bind reset_strap_sampler rss_checker u_chk (
  .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_ext_reset_n(i_ext_reset_n),
  .i_supplies_stable(i_supplies_stable), .i_ext_clock_used(i_ext_clock_used),
  .i_hub_configured(i_hub_configured), .i_hub_suspended(i_hub_suspended),
  .o_core_rst(o_core_rst), .o_cfg_valid(o_cfg_valid),
  .o_cfg_strap_en(o_cfg_strap_en), .o_cfg_smbus_slave(o_cfg_smbus_slave),
  .o_cfg_eeprom_load(o_cfg_eeprom_load),
  .o_cfg_internal_default(o_cfg_internal_default),
  .o_smbus_addr(o_smbus_addr), .o_fixed_ports(o_fixed_ports),
  .o_clock_48m(o_clock_48m), .o_active_state_led(o_active_state_led),
  .o_active_state_led_oe(o_active_state_led_oe),
  .o_upstream_speed_led_oe(o_upstream_speed_led_oe));
